/* hw/jps_pkg.sv */
/*
 * Shared constants for the JTAG port select and port status block.
 * Assumes an access-port register space with 12-bit word-aligned offsets.
 */
// Notes on behaviour
// - Low byte selects which ports the engine drives.
// - Unattached select bits implemented as reading zero.
// - Port enabled needs attach, select and enable input.
// - Selected ports get same drive; returned data undefined.
// - Sticky disable flags reset to zero.
// - Attached selected port losing enable sets flag.
// - Flag holds until written one; zero ignored.
// - Set flag keeps its port disabled.
// - Unattached port flag always reads zero.
package jps_pkg;
    localparam int          NUM_PORTS       = 8;
    localparam int          ADDR_W          = 12;
    localparam int          DATA_W          = 32;
    localparam logic [11:0] PORT_SELECT_OFF = 12'hD04;
    localparam logic [11:0] PORT_STICKY_OFF = 12'hD08;
    localparam int          FIELD_LSB       = 0;
    localparam logic [7:0]  SELECT_RESET    = 8'h00;
    localparam logic [7:0]  STICKY_RESET    = 8'h00;
    localparam logic [7:0]  ATTACHED_ALL    = 8'hFF;
endpackage

/* hw/jps_sync.sv */
/*
 * Three-stage synchroniser for a level bus.
 * Assumes the input is quasi-static in its source domain or Gray-safe.
 */
`timescale 1ns/10ps
`default_nettype none
module jps_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Data
    input  wire logic [WIDTH-1:0] din,
    output var  logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    always_ff @(posedge clk) begin
        if (rst) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
        end else begin
            stage1 <= din;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // A bit changes only once the two later stages agree
    always_ff @(posedge clk) begin
        if (rst) begin
            dout <= '0;
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (stage2[i] == stage3[i]) begin
                    dout[i] <= stage3[i];
                end
            end
        end
    end
endmodule
`default_nettype wire

/* hw/jps_port_select.sv */
/*
 * Port selection and sticky port-disable status for a JTAG access port
 * that fans one serial engine out to up to eight downstream ports.
 * Registers live on clk_sys; the port drive runs on clk_link, the clock
 * the engine shifts on. Port enable inputs are treated as asynchronous.
 * Both resets are synchronous and either may be pulsed on its own.
 */
`timescale 1ns/10ps
`default_nettype none
module jps_port_select #(
    parameter logic [7:0] ATTACHED = jps_pkg::ATTACHED_ALL
) (
    // System clock domain
    input  wire logic                        clk_sys,
    input  wire logic                        rst,
    // Register access
    input  wire logic [jps_pkg::ADDR_W-1:0]  reg_addr,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    input  wire logic [jps_pkg::DATA_W-1:0]  reg_wdata,
    output var  logic [jps_pkg::DATA_W-1:0]  reg_rdata,
    // Link clock domain
    input  wire logic                        clk_link,
    input  wire logic                        rst_link,
    // Engine side, on clk_link
    input  wire logic                        engine_tdi,
    input  wire logic                        engine_tms,
    input  wire logic                        engine_trst_n,
    input  wire logic                        engine_srst_n,
    output var  logic                        engine_tdo,
    // Downstream ports, drive on clk_link
    output var  logic [7:0]                  port_tdi,
    output var  logic [7:0]                  port_tms,
    output var  logic [7:0]                  port_trst_n,
    output var  logic [7:0]                  system_reset_out_n,
    input  wire logic [7:0]                  port_tdo,
    // Downstream ports, asynchronous status
    input  wire logic [7:0]                  port_enabled_input,
    // Status for the engine and system
    output var  logic [7:0]                  port_enabled
);
    localparam int NP = jps_pkg::NUM_PORTS;
    localparam int LS = jps_pkg::FIELD_LSB;

    // Register state
    logic [NP-1:0] port_select;
    logic [NP-1:0] port_disable_sticky;
    logic [NP-1:0] enabled_sync;

    // Crossing of the enable mask to the link domain
    logic [NP-1:0] xfer_mask;
    logic          req_tgl;
    logic          ack_sync;
    logic          req_sync;
    logic          ack_tgl;
    logic [NP-1:0] link_mask;

    logic          hit_select;
    logic          hit_sticky;
    logic          wr_select;
    logic          wr_sticky;
    logic [NP-1:0] wr_byte;
    logic [NP-1:0] next_enabled;
    logic [NP-1:0] lost_enable;
    logic [NP-1:0] sel_attached;

    // Exact offset match; any other offset reaches no register
    function automatic logic addr_hit(
        input logic [jps_pkg::ADDR_W-1:0] addr,
        input logic [jps_pkg::ADDR_W-1:0] offset
    );
        return addr == offset;
    endfunction

    assign hit_select = addr_hit(reg_addr, jps_pkg::PORT_SELECT_OFF);
    assign hit_sticky = addr_hit(reg_addr, jps_pkg::PORT_STICKY_OFF);
    assign wr_select  = reg_wr && hit_select;
    assign wr_sticky  = reg_wr && hit_sticky;
    assign wr_byte    = reg_wdata[LS +: NP];

    // Port enable inputs come from other domains
    jps_sync #(
        .WIDTH (NP)
    ) u_enable_sync (
        .clk  (clk_sys),
        .rst  (rst),
        .din  (port_enabled_input),
        .dout (enabled_sync)
    );

    // Unattached positions hold zero; upper bits ignored
    // Reset leaves every port deselected until software picks one
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            port_select <= jps_pkg::SELECT_RESET;
        end else if (wr_select) begin
            port_select <= wr_byte & ATTACHED;
        end
    end

    assign sel_attached = ATTACHED & port_select;

    // Level, not edge: while a selected port's enable stays low its flag
    // is set again every cycle, so a write-one clear only sticks once the
    // port is deselected or its enable has returned
    assign lost_enable = sel_attached & ~enabled_sync;

    // Set wins over a write-one clear in the same cycle
    // Writing zero to a flag leaves it as it is
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            port_disable_sticky <= jps_pkg::STICKY_RESET;
        end else begin
            for (int i = 0; i < NP; i++) begin
                if (lost_enable[i]) begin
                    port_disable_sticky[i] <= 1'b1;
                end else if (wr_sticky && wr_byte[i]) begin
                    port_disable_sticky[i] <= 1'b0;
                end
            end
        end
    end

    assign next_enabled = sel_attached & enabled_sync
                        & ~port_disable_sticky;

    // Registered so the crossing below sees one settled mask per edge
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            port_enabled <= '0;
        end else begin
            port_enabled <= next_enabled;
        end
    end

    // Register read port, one cycle latency
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            // Cleared first so bits 31:8 and unmapped offsets read zero
            reg_rdata <= '0;
            if (hit_select) begin
                reg_rdata[LS +: NP] <= port_select;
            end else if (hit_sticky) begin
                reg_rdata[LS +: NP] <= port_disable_sticky & ATTACHED;
            end
        end
    end

    // Toggle handshake carries the mask to clk_link; a new mask waits
    // until the previous one has been acknowledged
    jps_sync #(
        .WIDTH (1)
    ) u_ack_sync (
        .clk  (clk_sys),
        .rst  (rst),
        .din  (ack_tgl),
        .dout (ack_sync)
    );

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            xfer_mask <= '0;
            req_tgl   <= 1'b0;
        end else if ((ack_sync == req_tgl) && (xfer_mask != port_enabled)) begin
            xfer_mask <= port_enabled;
            req_tgl   <= ~req_tgl;
        end
    end

    jps_sync #(
        .WIDTH (1)
    ) u_req_sync (
        .clk  (clk_link),
        .rst  (rst_link),
        .din  (req_tgl),
        .dout (req_sync)
    );

    // xfer_mask is held stable until the ack returns. If one reset is
    // pulsed alone the toggles differ only if that side's toggle was 1, else link_mask stays stale; the next exchange realigns them
    always_ff @(posedge clk_link) begin
        if (rst_link) begin
            link_mask <= '0;
            ack_tgl   <= 1'b0;
        end else if (req_sync != ack_tgl) begin
            link_mask <= xfer_mask;
            ack_tgl   <= req_sync;
        end
    end

    // Same engine drive to every enabled port; idle values elsewhere
    // Idle holds TDI and TMS low and both resets released
    always_ff @(posedge clk_link) begin
        if (rst_link) begin
            port_tdi           <= '0;
            port_tms           <= '0;
            port_trst_n        <= '1;
            system_reset_out_n <= '1;
        end else begin
            for (int i = 0; i < NP; i++) begin
                port_tdi[i]           <= link_mask[i] & engine_tdi;
                port_tms[i]           <= link_mask[i] & engine_tms;
                port_trst_n[i]        <= ~link_mask[i] | engine_trst_n;
                system_reset_out_n[i] <= ~link_mask[i] | engine_srst_n;
            end
        end
    end

    // Several ports selected: returned bit is the OR, not meaningful.
    // Unselected ports are masked so a floating return cannot leak in
    always_ff @(posedge clk_link) begin
        if (rst_link) begin
            engine_tdo <= 1'b0;
        end else begin
            engine_tdo <= |(port_tdo & link_mask);
        end
    end
endmodule
`default_nettype wire

/* test/jps_port_select_assertions.sv */
/* Port checks for jps_port_select, bound to every instance.
   Assumes the register port and resets behave as the design notes say. */
`timescale 1ns/10ps
`default_nettype none
module jps_port_select_assertions #(
    parameter logic [7:0] ATTACHED = 8'hFF
) (
    // Clock, reset and register port
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic [11:0] reg_addr,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    // Port enables
    input wire logic [7:0]  port_enabled_input,
    input wire logic [7:0]  port_enabled
);
    logic [7:0] sel_q;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Select value as last written
    always_ff @(posedge clk_sys) begin
        if (rst)
            sel_q <= 8'h00;
        else if (reg_wr && reg_addr == 12'hD04)
            sel_q <= reg_wdata[7:0];
    end
    chk_high_zero: assert property (reg_rdata[31:8] == 24'h000000)
        else $error("upper read bits set");
    chk_unattached_zero: assert property (
        (reg_rdata[7:0] & ~ATTACHED) == 8'h00) else $error("unattached bit");
    chk_reset_clear: assert property ($fell(rst) |->
        reg_rdata == 32'h00000000 && port_enabled == 8'h00)
        else $error("reset state wrong");
    chk_enable_attached: assert property (
        (port_enabled & ~ATTACHED) == 8'h00) else $error("unattached enabled");
    chk_enable_select: assert property (
        (port_enabled & ~sel_q & ~$past(sel_q)) == 8'h00)
        else $error("deselected port enabled");
    chk_enable_drop: assert property (
        !port_enabled_input[1] [*6] |-> !port_enabled[1])
        else $error("port kept enabled");
    chk_unmapped_read: assert property (
        reg_rd && reg_addr != 12'hD04 && reg_addr != 12'hD08
        |=> reg_rdata == 32'h00000000) else $error("unmapped read not zero");
    chk_select_read: assert property (reg_rd && reg_addr == 12'hD04
        |=> reg_rdata == {24'h000000, ($past(sel_q) & ATTACHED)})
        else $error("select read wrong");
endmodule
bind jps_port_select jps_port_select_assertions #(.ATTACHED(ATTACHED))
    chk_inst (.clk_sys, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .reg_rdata, .port_enabled_input, .port_enabled);
`default_nettype wire

/* test/jps_tap_model.sv */
/* Downstream TAP chain model for jps_port_select.
   Echoes port_tdi one link clock late; en_off drops port enables. */
`timescale 1ns/10ps
`default_nettype none
module jps_tap_model (
    // Link side and enable control
    input  wire logic       clk_link,
    input  wire logic [7:0] port_tdi,
    input  wire logic [7:0] en_off,
    output var  logic [7:0] port_tdo,
    output var  logic [7:0] port_enabled_input
);
    assign port_enabled_input = ~en_off;
    // A disabled chain toggles its output instead of holding it
    always_ff @(posedge clk_link) begin
        port_tdo <= (port_tdi & ~en_off) | (~port_tdo & en_off);
    end
endmodule
`default_nettype wire

/* test/jps_port_select_tb_top.sv */
/* Bench for jps_port_select with port 7 unattached.
   Relies on the bound checker and the TAP chain model. */
`timescale 1ns/10ps
`default_nettype none
module jps_port_select_tb_top;
    logic        clk_sys = 1'b0, clk_link = 1'b0, rst = 1'b1, rst_link = 1'b1;
    logic        reg_wr = 1'b0, reg_rd = 1'b0, engine_tdi = 1'b0;
    logic        engine_tms = 1'b0, engine_trst_n = 1'b1, engine_srst_n = 1'b1;
    logic        engine_tdo;
    logic [11:0] reg_addr = 12'h000;
    logic [31:0] reg_wdata = 32'h00000000, reg_rdata, v;
    logic [7:0]  port_tdi, port_tms, port_trst_n, system_reset_out_n;
    logic [7:0]  port_tdo, port_enabled_input, port_enabled, en_off = 8'h00;
    logic [79:0] r;
    int          err_total = 0, n_tests = 0;
    // Enables off, write address and data, read address, read and enables
    logic [79:0] rows [6] = '{80'h00_D04_FFFFFFFF_D04_7F_7F,
        80'h00_D10_000000FF_D10_00_7F, 80'h00_D04_00000183_D04_03_03,
        80'h82_D08_00000000_D08_02_01, 80'h00_D08_00000000_D08_02_01,
        80'h00_D08_00000002_D08_00_03};
    jps_port_select #(.ATTACHED(8'h7F)) jps_port_select_inst (.clk_sys, .rst,
        .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .clk_link,
        .rst_link, .engine_tdi, .engine_tms, .engine_trst_n, .engine_srst_n,
        .engine_tdo, .port_tdi, .port_tms, .port_trst_n, .system_reset_out_n,
        .port_tdo, .port_enabled_input, .port_enabled);
    jps_tap_model jps_tap_model_inst (.clk_link, .port_tdi, .en_off,
        .port_tdo, .port_enabled_input);
    initial forever #2.5 clk_sys = ~clk_sys;
    initial #1.3 forever #3 clk_link = ~clk_link;
    task automatic chk(input logic [31:0] seen, exp, input string what);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Writes are issued both while the engine is idle and while it drives
    task automatic bus(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr <= w;
        reg_rd <= ~w;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (4) @(posedge clk_link);
        rst_link <= 1'b0;
        foreach (rows[i]) begin
            r = rows[i];
            @(posedge clk_sys);
            en_off <= r[79:72];
            bus(1'b1, r[71:60], r[59:28]);
            repeat (12) @(posedge clk_sys);
            bus(1'b0, r[27:16], 32'h00000000);
            chk(v, {24'h000000, r[15:8]}, "read");
            chk({24'h000000, port_enabled}, {24'h000000, r[7:0]}, "en");
        end
        @(posedge clk_link);
        engine_tdi <= 1'b1;
        engine_tms <= 1'b1;
        engine_trst_n <= 1'b0;
        engine_srst_n <= 1'b0;
        // Each port is set up alone before both are selected together
        for (int p = 0; p < 2; p++) begin
            bus(1'b1, 12'hD04, 32'h00000001 << p);
            repeat (16) @(posedge clk_sys);
            chk({24'h000000, port_tms}, 32'h00000001 << p, "solo");
        end
        bus(1'b1, 12'hD04, 32'h00000003);
        repeat (20) @(posedge clk_link);
        #1 v = {port_tdi, port_tms, port_trst_n, 7'h00, engine_tdo};
        chk(v, 32'h0303FC01, "drive");
        chk({24'h000000, system_reset_out_n}, 32'h000000FC, "srst");
        @(posedge clk_sys);
        en_off <= 8'h01;
        repeat (8) @(posedge clk_sys);
        bus(1'b0, 12'hD08, 32'h00000000);
        chk(v, 32'h00000001, "sticky before reset");
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        bus(1'b0, 12'hD08, 32'h00000000);
        chk(v, 32'h00000000, "sticky after reset");
        stop_test;
    end
    initial begin
        #20000 err_total++;
        stop_test;
    end
endmodule
`default_nettype wire
